// >>> rtl/dcwd_consts.svh
// Constants for the drive command word decoder
`ifndef DCWD_CONSTS_SVH
`define DCWD_CONSTS_SVH

// ****************************************
// Frame fields
// ****************************************
`define DCWD_FUNC_WR_MULTI   8'h10
`define DCWD_BCAST_ADDR      8'h00
`define DCWD_REG_NUM_BIAS    16'h0001
`define DCWD_CMD_REG_NUM     16'h0010
`define DCWD_MAX_REG_COUNT   16'h007B
`define DCWD_RESP_BYTES      3'h6
`define DCWD_HREG_DEPTH      8

// ****************************************
// Reset values
// ****************************************
`define DCWD_CMD_RESET       16'h0000
`define DCWD_SLAVE_ADDR_DEF  8'h01

// ****************************************
// Command word bit positions
// ****************************************
`define DCWD_B_REF_LSB       0
`define DCWD_B_REF_MSB       1
`define DCWD_B_RAMP          2
`define DCWD_B_NO_COAST      3
`define DCWD_B_NO_QSTOP      4
`define DCWD_B_USE_RAMP      5
`define DCWD_B_START         6
`define DCWD_B_RESET         7
`define DCWD_B_JOG           8
`define DCWD_B_RAMP2         9
`define DCWD_B_VALID         10
`define DCWD_B_RELAY1        11
`define DCWD_B_RELAY2        12
`define DCWD_B_SETUP_LSB     13
`define DCWD_B_SETUP_MSB     14
`define DCWD_B_REVERSE       15

`endif

// >>> rtl/dcwd_pkg.sv
// Types shared by the drive command word decoder
package dcwd_pkg;

  // ****************************************
  // Source selection for gated functions
  // ****************************************
  typedef enum logic [1:0] {
    SRC_DIGITAL,
    SRC_SERIAL,
    SRC_LOGIC_OR,
    SRC_LOGIC_AND
  } dcwd_src_t;

  // ****************************************
  // Digital inputs, high means function requested
  // ****************************************
  typedef struct packed {
    logic       coast;
    logic       start;
    logic [1:0] preset;
    logic [1:0] setup;
    logic       reverse;
    logic       dc_brake;
    logic       coast_stop;
    logic       reset_coast;
    logic       speed_up;
    logic       slow_down;
  } dcwd_din_t;

  // ****************************************
  // Configuration settings
  // ****************************************
  typedef struct packed {
    dcwd_src_t  coast_src;
    dcwd_src_t  start_src;
    dcwd_src_t  preset_src;
    dcwd_src_t  setup_src;
    dcwd_src_t  reverse_src;
    logic       relay1_on_cmd;
    logic       relay2_on_cmd;
    logic       multi_setup;
    logic [1:0] active_setup;
  } dcwd_cfg_t;

  // ****************************************
  // Actions towards the drive
  // ****************************************
  typedef struct packed {
    logic [1:0] preset_ref;
    logic       dc_brake;
    logic       coast;
    logic       quick_stop;
    logic       freeze;
    logic       ramp_stop;
    logic       trip_reset;
    logic       jog;
    logic       ramp2;
    logic       relay1;
    logic       relay2;
    logic [1:0] setup;
    logic       reverse;
    logic       freq_up;
    logic       freq_down;
  } dcwd_act_t;

endpackage

// >>> rtl/dcwd_src_combine.sv
// Combines a serial command with a digital input per source setting
`timescale 1ns/1ps
module dcwd_src_combine #(
  parameter int W = 1
) (
  input  wire dcwd_pkg::dcwd_src_t sel,
  input  wire logic [W-1:0]        ser,
  input  wire logic [W-1:0]        din,
  output logic      [W-1:0]        res
);

  always_comb begin
    case (sel)
      dcwd_pkg::SRC_DIGITAL:   res = din;
      dcwd_pkg::SRC_SERIAL:    res = ser;
      dcwd_pkg::SRC_LOGIC_OR:  res = ser | din;
      dcwd_pkg::SRC_LOGIC_AND: res = ser & din;
      default:                 res = din;
    endcase
  end

endmodule // dcwd_src_combine

// >>> rtl/dcwd_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dcwd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // dcwd_sync

// >>> rtl/dcwd_top.sv
// Drive command word decoder with multi-register write handling
`timescale 1ns/1ps
`include "dcwd_consts.svh"
module dcwd_top #(
  parameter int          HREG_DEPTH = `DCWD_HREG_DEPTH,
  parameter logic [15:0] CMD_REG_NUM = `DCWD_CMD_REG_NUM
) (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic [7:0]                 slave_addr,
  input  wire logic                       rx_valid,
  input  wire logic [7:0]                 rx_data,
  input  wire logic                       rx_end,
  input  wire logic                       rx_error,
  input  wire logic                       tx_ready,
  output logic                            tx_valid,
  output logic      [7:0]                 tx_data,
  output logic                            tx_last,
  input  wire dcwd_pkg::dcwd_din_t        din_pins,
  input  wire dcwd_pkg::dcwd_cfg_t        cfg,
  output dcwd_pkg::dcwd_act_t             act,
  output logic      [HREG_DEPTH-1:0][15:0] hreg_q
);

  // ****************************************
  // Register window
  // ****************************************
  localparam logic [15:0] WIN_BASE = CMD_REG_NUM - `DCWD_REG_NUM_BIAS;
  localparam logic [15:0] WIN_SIZE = 16'(HREG_DEPTH);
  localparam int          IDX_W    = (HREG_DEPTH > 1) ? $clog2(HREG_DEPTH) : 1;

  function automatic logic in_window(input logic [15:0] wire_addr);
    logic [15:0] off;
    off = wire_addr - WIN_BASE;
    return (wire_addr >= WIN_BASE) && (off < WIN_SIZE);
  endfunction

  function automatic logic [IDX_W-1:0] win_index(input logic [15:0] wire_addr);
    logic [15:0] off;
    off = wire_addr - WIN_BASE;
    return off[IDX_W-1:0];
  endfunction

  // ****************************************
  // Frame parser state
  // ****************************************
  typedef enum logic [3:0] {
    ST_ADDR,
    ST_FUNC,
    ST_SA_HI,
    ST_SA_LO,
    ST_CNT_HI,
    ST_CNT_LO,
    ST_BCNT,
    ST_DAT_HI,
    ST_DAT_LO,
    ST_DONE,
    ST_SKIP,
    ST_TX
  } dcwd_state_t;

  dcwd_state_t state_q;
  logic [7:0]  addr_q;
  logic [15:0] start_q;
  logic [15:0] count_q;
  logic [15:0] done_q;
  logic [7:0]  data_hi_q;
  logic [2:0]  tx_idx_q;

  logic [15:0] cur_addr;
  logic [15:0] wr_word;
  logic        wr_en;
  logic        cmd_wr;
  logic [15:0] count_nx;

  always_comb begin
    cur_addr = start_q + done_q;
    wr_word  = {data_hi_q, rx_data};
    count_nx = {count_q[15:8], rx_data};
    wr_en    = rx_valid && !rx_error && (state_q == ST_DAT_LO) && in_window(cur_addr);
    cmd_wr   = wr_en && (win_index(cur_addr) == '0);
  end

  // ****************************************
  // Request decoding
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q   <= ST_ADDR;
      addr_q    <= 8'h00;
      start_q   <= 16'h0000;
      count_q   <= 16'h0000;
      done_q    <= 16'h0000;
      data_hi_q <= 8'h00;
    end else if (state_q == ST_TX) begin
      if (tx_valid && tx_ready && tx_last) begin
        state_q <= ST_ADDR;
      end
    end else if (rx_end) begin
      if (state_q == ST_DONE && addr_q != `DCWD_BCAST_ADDR) begin
        state_q <= ST_TX;
      end else begin
        state_q <= ST_ADDR;
      end
    end else if (rx_error) begin
      state_q <= ST_SKIP;
    end else if (rx_valid) begin
      case (state_q)
        ST_ADDR: begin
          addr_q <= rx_data;
          if (rx_data == slave_addr || rx_data == `DCWD_BCAST_ADDR) begin
            state_q <= ST_FUNC;
          end else begin
            state_q <= ST_SKIP;
          end
        end
        ST_FUNC: begin
          state_q <= (rx_data == `DCWD_FUNC_WR_MULTI) ? ST_SA_HI : ST_SKIP;
        end
        ST_SA_HI: begin
          start_q[15:8] <= rx_data;
          state_q       <= ST_SA_LO;
        end
        ST_SA_LO: begin
          start_q[7:0] <= rx_data;
          state_q      <= ST_CNT_HI;
        end
        ST_CNT_HI: begin
          count_q[15:8] <= rx_data;
          state_q       <= ST_CNT_LO;
        end
        ST_CNT_LO: begin
          count_q[7:0] <= rx_data;
          if (count_nx == 16'h0000 || count_nx > `DCWD_MAX_REG_COUNT) begin
            state_q <= ST_SKIP;
          end else begin
            state_q <= ST_BCNT;
          end
        end
        ST_BCNT: begin
          done_q <= 16'h0000;
          if ({8'h00, rx_data} == {count_q[14:0], 1'b0}) begin
            state_q <= ST_DAT_HI;
          end else begin
            state_q <= ST_SKIP;
          end
        end
        ST_DAT_HI: begin
          data_hi_q <= rx_data;
          state_q   <= ST_DAT_LO;
        end
        ST_DAT_LO: begin
          done_q  <= done_q + 16'h0001;
          state_q <= (done_q + 16'h0001 == count_q) ? ST_DONE : ST_DAT_HI;
        end
        ST_DONE: begin
          state_q <= ST_SKIP;
        end
        ST_SKIP: begin
          state_q <= ST_SKIP;
        end
        default: begin
          state_q <= ST_SKIP;
        end
      endcase
    end
  end

  // ****************************************
  // Holding registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hreg_q <= '0;
    end else if (wr_en) begin
      hreg_q[win_index(cur_addr)] <= wr_word;
    end
  end

  // ****************************************
  // Response transmitter
  // ****************************************
  function automatic logic [7:0] resp_byte(input logic [2:0] idx);
    case (idx)
      3'h0:    return addr_q;
      3'h1:    return `DCWD_FUNC_WR_MULTI;
      3'h2:    return start_q[15:8];
      3'h3:    return start_q[7:0];
      3'h4:    return count_q[15:8];
      3'h5:    return count_q[7:0];
      default: return 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_idx_q <= 3'h0;
    end else if (state_q != ST_TX) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      tx_idx_q <= 3'h0;
      if (rx_end && state_q == ST_DONE && addr_q != `DCWD_BCAST_ADDR) begin
        tx_valid <= 1'b1;
        tx_data  <= resp_byte(3'h0);
        tx_idx_q <= 3'h1;
      end
    end else if (tx_valid && tx_ready) begin
      if (tx_last) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end else begin
        tx_data  <= resp_byte(tx_idx_q);
        tx_last  <= (tx_idx_q == `DCWD_RESP_BYTES - 3'h1);
        tx_idx_q <= tx_idx_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Effective command word
  // ****************************************
  logic [15:0] eff_q;
  logic        reset_pulse_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      eff_q         <= `DCWD_CMD_RESET;
      reset_pulse_q <= 1'b0;
    end else begin
      reset_pulse_q <= 1'b0;
      if (cmd_wr && wr_word[`DCWD_B_VALID]) begin
        eff_q         <= wr_word;
        reset_pulse_q <= wr_word[`DCWD_B_RESET] && !eff_q[`DCWD_B_RESET];
      end
    end
  end

  // ****************************************
  // Digital inputs
  // ****************************************
  dcwd_pkg::dcwd_din_t din;

  dcwd_sync #(
    .W ($bits(dcwd_pkg::dcwd_din_t))
  ) u_din_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (din_pins),
    .sync_out (din)
  );

  // ****************************************
  // Source combination
  // ****************************************
  logic       coast_c;
  logic       start_c;
  logic [1:0] preset_c;
  logic [1:0] setup_c;
  logic       reverse_c;

  dcwd_src_combine #(.W(1)) u_coast (
    .sel (cfg.coast_src),
    .ser (!eff_q[`DCWD_B_NO_COAST]),
    .din (din.coast),
    .res (coast_c)
  );

  dcwd_src_combine #(.W(1)) u_start (
    .sel (cfg.start_src),
    .ser (eff_q[`DCWD_B_START]),
    .din (din.start),
    .res (start_c)
  );

  dcwd_src_combine #(.W(2)) u_preset (
    .sel (cfg.preset_src),
    .ser (eff_q[`DCWD_B_REF_MSB:`DCWD_B_REF_LSB]),
    .din (din.preset),
    .res (preset_c)
  );

  dcwd_src_combine #(.W(2)) u_setup (
    .sel (cfg.setup_src),
    .ser (eff_q[`DCWD_B_SETUP_MSB:`DCWD_B_SETUP_LSB]),
    .din (din.setup),
    .res (setup_c)
  );

  dcwd_src_combine #(.W(1)) u_reverse (
    .sel (cfg.reverse_src),
    .ser (eff_q[`DCWD_B_REVERSE]),
    .din (din.reverse),
    .res (reverse_c)
  );

  // ****************************************
  // Drive actions
  // ****************************************
  logic frozen;

  always_comb begin
    frozen = !eff_q[`DCWD_B_USE_RAMP];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      act <= '0;
    end else begin
      act.preset_ref <= preset_c;
      act.dc_brake   <= !eff_q[`DCWD_B_RAMP] || din.dc_brake;
      act.coast      <= coast_c || din.coast_stop || din.reset_coast;
      act.quick_stop <= !eff_q[`DCWD_B_NO_QSTOP] && !frozen;
      act.freeze     <= frozen;
      act.ramp_stop  <= !start_c && !frozen;
      act.trip_reset <= reset_pulse_q;
      act.jog        <= eff_q[`DCWD_B_JOG];
      act.ramp2      <= eff_q[`DCWD_B_RAMP2];
      act.relay1     <= eff_q[`DCWD_B_RELAY1] && cfg.relay1_on_cmd;
      act.relay2     <= eff_q[`DCWD_B_RELAY2] && cfg.relay2_on_cmd;
      act.setup      <= cfg.multi_setup ? setup_c : cfg.active_setup;
      act.reverse    <= reverse_c;
      act.freq_up    <= frozen && din.speed_up;
      act.freq_down  <= frozen && din.slow_down;
    end
  end

endmodule // dcwd_top

// >>> sim/dcwd_master.sv
// Bus master model sending write requests and taking replies
`timescale 1ns/1ps
module dcwd_master (
  input  wire logic       clk_sys,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            rx_error,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last
);
  logic [7:0] rep_q[$];
  logic       done_q = 1'b0;
  logic       stall_en = 1'b1;
  initial begin
    {rx_valid, rx_data, rx_end, rx_error, tx_ready} = '0;
  end
  // Random stalls on the reply side
  always @(posedge clk_sys) tx_ready <= stall_en ? ($urandom_range(3) != 0) : 1'b1;
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      rep_q.push_back(tx_data);
      if (tx_last) done_q <= 1'b1;
    end
  end
  task automatic send(input logic [7:0] a, input logic [15:0] num,
                      input logic [15:0] w[$], input int err_at);
    logic [15:0] s;
    logic [7:0]  b[$];
    s = num - 16'h0001;
    b = {a, 8'h10, s[15:8], s[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
    foreach (w[i]) b = {b, w[i][15:8], w[i][7:0]};
    // Refused frames: bad byte count or foreign function
    if (err_at == -2) b[6] = b[6] + 8'h01;
    if (err_at == -3) b[1] = 8'h03;
    rep_q.delete();
    done_q = 1'b0;
    foreach (b[i]) begin
      @(posedge clk_sys);
      if (i == err_at) begin
        rx_error <= 1'b1;
        break;
      end
      rx_valid <= 1'b1;
      rx_data  <= b[i];
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_data  <= ~b[i];
    end
    @(posedge clk_sys);
    rx_error <= 1'b0;
    rx_end   <= 1'b1;
    @(posedge clk_sys);
    rx_end   <= 1'b0;
  endtask
endmodule // dcwd_master

// >>> sim/dcwd_top_sva.sv
// Assertion checker for the drive command word decoder
`timescale 1ns/1ps
module dcwd_top_sva #(
  parameter int HREG_DEPTH = 8
) (
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic [7:0]                  slave_addr,
  input wire logic                        rx_valid,
  input wire logic [7:0]                  rx_data,
  input wire logic                        rx_end,
  input wire logic                        rx_error,
  input wire logic                        tx_ready,
  input wire logic                        tx_valid,
  input wire logic [7:0]                  tx_data,
  input wire logic                        tx_last,
  input wire dcwd_pkg::dcwd_din_t         din_pins,
  input wire dcwd_pkg::dcwd_cfg_t         cfg,
  input wire dcwd_pkg::dcwd_act_t         act,
  input wire logic [HREG_DEPTH-1:0][15:0] hreg_q
);
  logic [2:0] n_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Reply bytes accepted so far
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (tx_valid && tx_ready && tx_last)) n_q <= 3'h0;
    else if (tx_valid && tx_ready) n_q <= n_q + 3'h1;
  end
  a_tx_hold_stable: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("reply byte moved");
  a_reply_six_bytes: assert property (tx_valid && tx_ready && tx_last |->
    n_q == 3'h5) else $error("reply length wrong");
  a_last_ends: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("reply ran past last");
  a_last_valid: assert property (tx_last |-> tx_valid) else $error("last without valid");
  a_trip_pulse: assert property (act.trip_reset |=> !act.trip_reset)
    else $error("trip reset repeated");
  a_freeze_ramp: assert property (act.freeze |-> !act.quick_stop && !act.ramp_stop)
    else $error("ramp stop while held");
  a_relay1_cfg: assert property (!$past(cfg.relay1_on_cmd) |-> !act.relay1)
    else $error("relay one not gated");
  a_relay2_cfg: assert property (!$past(cfg.relay2_on_cmd) |-> !act.relay2)
    else $error("relay two not gated");
  a_setup_fixed: assert property (!$past(sys_rst) && !$past(cfg.multi_setup) |->
    act.setup == $past(cfg.active_setup)) else $error("setup not fixed");
  c_reply_done: cover property (tx_valid && tx_ready && tx_last);
  c_trip: cover property (act.trip_reset);
  c_freeze: cover property (act.freeze && act.coast);
endmodule // dcwd_top_sva

bind dcwd_top dcwd_top_sva #(.HREG_DEPTH(HREG_DEPTH)) u_sva (.clk_sys, .sys_rst, .slave_addr,
  .rx_valid, .rx_data, .rx_end, .rx_error, .tx_ready, .tx_valid, .tx_data, .tx_last,
  .din_pins, .cfg, .act, .hreg_q);

// >>> sim/drive_control_word_decoder_bench.sv
// Self-checking bench for the drive command word decoder
`timescale 1ns/1ps
`include "dcwd_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module drive_control_word_decoder_bench;
  localparam logic [15:0] CREG = `DCWD_CMD_REG_NUM;
  logic                clk_sys, sys_rst, rx_valid, rx_end, rx_error, tx_ready, tx_valid, tx_last;
  logic [7:0]          slave_addr, rx_data, tx_data;
  dcwd_pkg::dcwd_din_t din_pins;
  dcwd_pkg::dcwd_cfg_t cfg;
  dcwd_pkg::dcwd_act_t act;
  logic [7:0][15:0]    hreg_q;
  logic [15:0]         w, eff, mirror[8], words[$];
  int                  failures, checks, cyc, trips, exp_trips;
  logic [7:0]          ta[8] = '{8'h01, 8'h01, 8'h01, 8'h05, 8'h00, 8'h01, 8'h01, 8'h01};
  logic [15:0]         tr[8] = '{CREG - 16'h0001, CREG + 16'h0002, CREG + 16'h0006,
                                 CREG, CREG + 16'h0001, CREG, CREG, CREG};
  int                  tn[8] = '{8, 3, 3, 1, 2, 2, 1, 1};
  int                  te[8] = '{-1, -1, -1, -1, -1, 7, -2, -3};
  dcwd_top dut (.clk_sys, .sys_rst, .slave_addr, .rx_valid, .rx_data, .rx_end, .rx_error,
    .tx_ready, .tx_valid, .tx_data, .tx_last, .din_pins, .cfg, .act, .hreg_q);
  dcwd_master m (.clk_sys, .rx_valid, .rx_data, .rx_end, .rx_error, .tx_ready, .tx_valid,
    .tx_data, .tx_last);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (act.trip_reset === 1'b1 && !sys_rst) trips++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [1:0] cmb(dcwd_pkg::dcwd_src_t s, logic [1:0] v, logic [1:0] d);
    case (s)
      dcwd_pkg::SRC_SERIAL:    return v;
      dcwd_pkg::SRC_LOGIC_OR:  return v | d;
      dcwd_pkg::SRC_LOGIC_AND: return v & d;
      default:                 return d;
    endcase
  endfunction
  function automatic dcwd_pkg::dcwd_act_t exp_act(logic [15:0] c);
    dcwd_pkg::dcwd_act_t a;
    a = '0;
    a.preset_ref = cmb(cfg.preset_src, c[1:0], din_pins.preset);
    a.dc_brake   = !c[2] || din_pins.dc_brake;
    a.coast      = cmb(cfg.coast_src, {1'b0, !c[3]}, {1'b0, din_pins.coast}) != 0 ||
                   din_pins.coast_stop || din_pins.reset_coast;
    a.freeze     = !c[5];
    a.freq_up    = !c[5] && din_pins.speed_up;
    a.freq_down  = !c[5] && din_pins.slow_down;
    a.quick_stop = !c[4] && c[5];
    a.ramp_stop  = cmb(cfg.start_src, {1'b0, c[6]}, {1'b0, din_pins.start}) == 0 && c[5];
    a.jog        = c[8];
    a.ramp2      = c[9];
    a.relay1     = c[11] && cfg.relay1_on_cmd;
    a.relay2     = c[12] && cfg.relay2_on_cmd;
    a.setup      = cfg.multi_setup ? cmb(cfg.setup_src, c[14:13], din_pins.setup) :
                   cfg.active_setup;
    a.reverse    = cmb(cfg.reverse_src, {1'b0, c[15]}, {1'b0, din_pins.reverse}) != 0;
    return a;
  endfunction
  task automatic xfer(input logic [7:0] a, input logic [15:0] num, input int err_at);
    logic [15:0] s;
    logic [7:0]  e[$];
    int          k;
    s = num - 16'h0001;
    e = {a, 8'h10, s[15:8], s[7:0], 8'h00, 8'(words.size())};
    m.send(a, num, words, err_at);
    k = 0;
    while (m.done_q !== 1'b1 && k < 80) begin
      @(posedge clk_sys);
      k++;
    end
    if (a == slave_addr && err_at == -1) begin
      `CHK(m.rep_q.size(), 6)
      foreach (e[i]) `CHK(m.rep_q[i], e[i])
    end
    else `CHK(m.rep_q.size(), 0)
    foreach (words[j]) begin
      k = int'(num) - int'(CREG) + j;
      if (err_at == -1 && (a == slave_addr || a == 8'h00) && k >= 0 && k < 8) begin
        mirror[k] = words[j];
        if (k == 0 && words[j][10]) begin
          if (words[j][7] && !eff[7]) exp_trips++;
          eff = words[j];
        end
      end
    end
    for (int i = 0; i < 8; i++) `CHK(hreg_q[i], mirror[i])
    repeat (3) @(posedge clk_sys);
    `CHK(act, exp_act(eff))
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'ha6e5));
    sys_rst = 1'b1;
    slave_addr = 8'h01;
    din_pins = '0;
    cfg = '0;
    eff = 16'h0000;
    foreach (mirror[i]) mirror[i] = 16'h0000;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(act, exp_act(eff))
    for (int i = 0; i < 16; i++) begin
      cfg <= $bits(cfg)'($urandom);
      din_pins <= $bits(din_pins)'($urandom);
      w = 16'($urandom);
      w[10] = (i % 3 != 2);
      w[7] = i[0];
      words = {w};
      xfer(slave_addr, CREG, -1);
    end
    m.stall_en = 1'b0;
    for (int t = 0; t < 8; t++) begin
      cfg <= $bits(cfg)'($urandom);
      din_pins <= $bits(din_pins)'($urandom);
      words.delete();
      repeat (tn[t]) words.push_back(16'($urandom));
      xfer(ta[t], tr[t], te[t]);
    end
    `CHK(trips, exp_trips)
    tally_and_finish();
  end
endmodule // drive_control_word_decoder_bench
